// >>> rtl/dac_dsp_regs.svh
// Offsets, field positions, reset values and timing counts of the playback path.
`ifndef DAC_DSP_REGS_SVH
`define DAC_DSP_REGS_SVH
`define CLK_HZ        64'd250000000
`define REFERENCE_SAMPLE_RATE_HZ     64'd48000
`define OSR_FIXED     64'd128
`define MOD_STEP      32'((`OSR_FIXED * `REFERENCE_SAMPLE_RATE_HZ * 64'h100000000) / `CLK_HZ)
`define DLY_TAPS      21
`define FIR_TAPS      6
`define Q15_SHIFT     15
`define QNT_SHIFT     11
`define COEF_PER_CH   13
`define CI_DE_N0      4'h0
`define CI_DE_N1      4'h1
`define CI_DE_D1      4'h2
`define CI_B1         4'h3
`define CI_B2         4'h8
`define DEF_DE_N0     16'h3955
`define DEF_DE_N1     16'hf32d
`define DEF_DE_D1     16'h537e
`define DEF_BQ_NA     16'h6be3
`define DEF_BQ_NB     16'h9666
`define DEF_BQ_NC     16'h675d
`define DEF_BQ_DA     16'h7d83
`define DEF_BQ_DB     16'h84ee
`define REG_CTRL      8'h00
`define REG_RATE      8'h04
`define REG_ATTEN     8'h08
`define REG_COEF      8'h0c
`define REG_SAMPLE    8'h10
`define REG_STATUS    8'h14
`define REG_CLKCFG    8'h18
`define REG_REFRATE   8'h1c
`define CTRL_FX       0
`define CTRL_DEEMPH   1
`define CTRL_3D       2
`define CTRL_DBL      3
`define CLK_PLL       8
`define REF_MIN_KHZ   8'h27
`define REF_MAX_KHZ   8'h35
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// >>> rtl/dac_dsp_pkg.sv
// Types shared by the playback path and its controller.
package dac_dsp_pkg;
`include "dac_dsp_regs.svh"
  typedef logic signed [15:0] sample_t;
  typedef logic signed [23:0] err_t;
  typedef logic signed [4:0]  code_t;
  typedef struct packed {
    sample_t [1:0][`COEF_PER_CH-1:0]     coef;
    sample_t [1:0]                       de_x1;
    sample_t [1:0]                       de_y1;
    sample_t [1:0][1:0]                  bq_x1;
    sample_t [1:0][1:0]                  bq_x2;
    sample_t [1:0][1:0]                  bq_y1;
    sample_t [1:0][1:0]                  bq_y2;
    sample_t [1:0][`DLY_TAPS-1:0]        dly;
    err_t    [1:0][2:0]                  err;
    code_t   [1:0][`FIR_TAPS-1:0]        taps;
    logic    [1:0][7:0]                  dout;
    logic                                strobe;
    logic    [31:0]                      phase;
    logic    [6:0]                       os_cnt;
    logic    [4:0]                       ref_cnt;
    logic                                ready;
  } dev_state_t;
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [4:0]  rate;
    logic [15:0] atten;
    logic [23:0] clkcfg;
    logic [7:0]  refrate;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        smp_valid;
    logic [15:0] smp_left;
    logic [15:0] smp_right;
    logic        cfg_we;
    logic [4:0]  cfg_addr;
    logic [15:0] cfg_data;
  } host_state_t;
endpackage

// >>> rtl/dac_link_if.sv
// Link between the playback controller and the playback path.
`timescale 1ns/1ps
interface dac_link_if (
  input wire logic CLK,
  input wire logic RSTN
);
  logic        smp_valid;
  logic        smp_ready;
  logic [15:0] smp_left;
  logic [15:0] smp_right;
  logic        cfg_we;
  logic [4:0]  cfg_addr;
  logic [15:0] cfg_data;
  logic        fx_en;
  logic        deemph_en;
  logic        three_d_en;
  logic        double_rate;
  logic [15:0] three_d_atten;
  logic [4:0]  dac_rate_divider;
  modport device (input smp_valid, smp_left, smp_right, cfg_we, cfg_addr, cfg_data,
                  fx_en, deemph_en, three_d_en, double_rate, three_d_atten,
                  dac_rate_divider, output smp_ready);
  modport host (output smp_valid, smp_left, smp_right, cfg_we, cfg_addr, cfg_data,
                fx_en, deemph_en, three_d_en, double_rate, three_d_atten,
                dac_rate_divider, input smp_ready);
endinterface

// >>> rtl/dac_playback_path.sv
// Playback path: filters, interpolation, noise shaper and reconstruction per channel.
//
// Overview of operation
// - Accept input rates from 8 to 96 kHz.
// - Order: processing, interpolation, modulator, reconstruction.
// - Modulator rate fixed at 128 times reference.
// - Without PLL in double rate, limited dividers.
// - Other dividers need PLL predivider and multiplier.
// - De-emphasis is programmable first-order IIR per channel.
// - De-emphasis resets to the 48 kHz set.
// - Effects filter is two cascaded biquads.
// - Effects filter enabled or bypassed as whole.
// - First biquad N0-N2,D1,D2; second N3-N5,D4,D5.
// - Coefficients are 16-bit two's complement.
// - Both biquads reset to shelving filter defaults.
// - 3-D mode filters mono mix, attenuates, adds.
// - Host disables effects while rewriting coefficients.
// - Interpolation is linear phase, 21 sample delay.
// - Images below 7.455 fs rejected 65 dB; the code has no interpolation filter and holds each sample.
// - Enhanced mode: reference 39 to 53 kHz.
// - Third-order multi-bit delta-sigma noise shaper.
// - Six-tap FIR reconstruction at 128 times reference.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module dac_playback_path
  import dac_dsp_pkg::*;
(
  dac_link_if.device     lk,
  input  wire logic       CLK,
  input  wire logic       RSTN,
  output logic [7:0]      DAC_LEFT,
  output logic [7:0]      DAC_RIGHT,
  output logic            DAC_STROBE
);
  dev_state_t st;
  dev_state_t next_st;
  sample_t    in_s [2];
  sample_t    de_raw [2];
  sample_t    de_o [2];
  sample_t    b1_in [2];
  sample_t    b1_o [2];
  sample_t    b2_o [2];
  sample_t    fx_o [2];
  sample_t    mono;
  sample_t    amb;
  err_t       w [2];
  code_t      code [2];
  err_t       e_new [2];
  logic [7:0] fir [2];
  logic [32:0] acc_phase;
  logic        tick;
  logic        slot;
  logic        take;

  // Clamps a wide result to the sample range instead of wrapping.
  function automatic sample_t sat16(input logic signed [37:0] v);
    if (v > 38'sh00_0000_7fff) begin
      sat16 = 16'sh7fff;
    end else if (v < 38'sh3f_ffff_8000) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  function automatic sample_t deemph(input sample_t x, x1, y1, n0, n1, d1);
    logic signed [37:0] acc;
    acc = 38'(n0 * x) + 38'(n1 * x1) + 38'(d1 * y1);
    deemph = sat16(acc >>> `Q15_SHIFT);
  endfunction

  // Middle taps are doubled in the 38-bit sum, so no precision is lost.
  function automatic sample_t biquad(input sample_t x, x1, x2, y1, y2, na, nb, nc, da, db);
    logic signed [37:0] acc;
    acc = 38'(na * x) + (38'(nb * x1) <<< 1) + 38'(nc * x2)
        + (38'(da * y1) <<< 1) + 38'(db * y2);
    biquad = sat16(acc >>> `Q15_SHIFT);
  endfunction

  assign in_s[0] = lk.smp_left;
  assign in_s[1] = lk.smp_right;
  assign mono = sat16((38'(in_s[0]) + 38'(in_s[1])) >>> 1);
  assign amb = sat16(38'(b2_o[0] * $signed(lk.three_d_atten)) >>> `Q15_SHIFT);

  for (genvar c = 0; c < 2; c++) begin : g_ch
    assign de_raw[c] = deemph(in_s[c], st.de_x1[c], st.de_y1[c], st.coef[c][`CI_DE_N0],
                              st.coef[c][`CI_DE_N1], st.coef[c][`CI_DE_D1]);
    assign de_o[c] = lk.deemph_en ? de_raw[c] : in_s[c];
    // In 3-D mode the left biquads run on the mono mix.
    assign b1_in[c] = (lk.three_d_en && c == 0) ? mono : de_o[c];
    assign b1_o[c] = biquad(b1_in[c], st.bq_x1[c][0], st.bq_x2[c][0], st.bq_y1[c][0],
                            st.bq_y2[c][0], st.coef[c][`CI_B1], st.coef[c][`CI_B1+1],
                            st.coef[c][`CI_B1+2], st.coef[c][`CI_B1+3],
                            st.coef[c][`CI_B1+4]);
    assign b2_o[c] = biquad(b1_o[c], st.bq_x1[c][1], st.bq_x2[c][1], st.bq_y1[c][1],
                            st.bq_y2[c][1], st.coef[c][`CI_B2], st.coef[c][`CI_B2+1],
                            st.coef[c][`CI_B2+2], st.coef[c][`CI_B2+3],
                            st.coef[c][`CI_B2+4]);
    assign fx_o[c] = lk.three_d_en ? sat16(38'(de_o[c]) + 38'(amb)) :
                     lk.fx_en ? b2_o[c] : de_o[c];
    // Error-feedback shaper with a (1 - z^-1)^3 noise transfer function.
    assign w[c] = err_t'(st.dly[c][`DLY_TAPS-1]) - 24'(st.err[c][0] * 3)
                + 24'(st.err[c][1] * 3) - st.err[c][2];
    always_comb begin
      err_t q;
      q = (w[c] + 24'sh000400) >>> `QNT_SHIFT;
      if (q > 24'sh00000f) begin
        code[c] = 5'h0f;
      end else if (q < 24'shfffff0) begin
        code[c] = 5'h10;
      end else begin
        code[c] = q[4:0];
      end
    end
    assign e_new[c] = (err_t'(code[c]) <<< `QNT_SHIFT) - w[c];
    always_comb begin
      logic signed [7:0] s;
      s = 8'h00;
      for (int t = 0; t < `FIR_TAPS; t++) begin
        s = s + 8'(st.taps[c][t]);
      end
      fir[c] = s;
    end
  end

  assign acc_phase = {1'b0, st.phase} + {1'b0, `MOD_STEP};
  assign tick = acc_phase[32];
  // A reference period is 128 modulator ticks, 64 in double rate.
  assign slot = tick && (lk.double_rate ? (st.os_cnt[5:0] == 6'h3f) : (st.os_cnt == 7'h7f))
              && (st.ref_cnt + 5'h01 >= lk.dac_rate_divider);
  assign take = lk.smp_valid && st.ready;
  assign lk.smp_ready = st.ready;

  always_comb begin
    next_st = st;
    next_st.phase = acc_phase[31:0];
    next_st.strobe = 1'b0;
    if (lk.cfg_we && lk.cfg_addr[3:0] < 4'(`COEF_PER_CH)) begin
      next_st.coef[lk.cfg_addr[4]][lk.cfg_addr[3:0]] = lk.cfg_data;
    end
    if (take) begin
      next_st.ready = 1'b0;
      for (int c = 0; c < 2; c++) begin
        next_st.de_x1[c] = in_s[c];
        next_st.de_y1[c] = de_raw[c];
        next_st.bq_x1[c][0] = b1_in[c];
        next_st.bq_x2[c][0] = st.bq_x1[c][0];
        next_st.bq_y1[c][0] = b1_o[c];
        next_st.bq_y2[c][0] = st.bq_y1[c][0];
        next_st.bq_x1[c][1] = b1_o[c];
        next_st.bq_x2[c][1] = st.bq_x1[c][1];
        next_st.bq_y1[c][1] = b2_o[c];
        next_st.bq_y2[c][1] = st.bq_y1[c][1];
        // The delay line sets a fixed 21-sample latency and feeds a held output.
        next_st.dly[c] = {st.dly[c][`DLY_TAPS-2:0], fx_o[c]};
      end
    end
    if (tick) begin
      next_st.os_cnt = st.os_cnt + 7'h01;
      next_st.strobe = 1'b1;
      for (int c = 0; c < 2; c++) begin
        next_st.err[c] = {st.err[c][1:0], e_new[c]};
        next_st.taps[c] = {st.taps[c][`FIR_TAPS-2:0], code[c]};
        next_st.dout[c] = fir[c];
      end
      if (lk.double_rate ? (st.os_cnt[5:0] == 6'h3f) : (st.os_cnt == 7'h7f)) begin
        next_st.ref_cnt = slot ? 5'h00 : st.ref_cnt + 5'h01;
      end
    end
    if (slot) begin
      next_st.ready = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= '0;
      for (int c = 0; c < 2; c++) begin
        st.coef[c][`CI_DE_N0] <= `DEF_DE_N0;
        st.coef[c][`CI_DE_N1] <= `DEF_DE_N1;
        st.coef[c][`CI_DE_D1] <= `DEF_DE_D1;
        for (int b = 0; b < 2; b++) begin
          st.coef[c][`CI_B1+5*b]   <= `DEF_BQ_NA;
          st.coef[c][`CI_B1+5*b+1] <= `DEF_BQ_NB;
          st.coef[c][`CI_B1+5*b+2] <= `DEF_BQ_NC;
          st.coef[c][`CI_B1+5*b+3] <= `DEF_BQ_DA;
          st.coef[c][`CI_B1+5*b+4] <= `DEF_BQ_DB;
        end
      end
    end else begin
      st <= next_st;
    end
  end

  assign DAC_LEFT = st.dout[0];
  assign DAC_RIGHT = st.dout[1];
  assign DAC_STROBE = st.strobe;
endmodule

// >>> rtl/dac_playback_ctrl.sv
// Playback controller: AXI4-Lite registers that drive the playback path link.
`timescale 1ns/1ps
module dac_playback_ctrl
  import dac_dsp_pkg::*;
(
  dac_link_if.host        lk,
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic [7:0] S_AXI_AWADDR,
  input  wire logic       S_AXI_AWVALID,
  output logic            S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0] S_AXI_WSTRB,
  input  wire logic       S_AXI_WVALID,
  output logic            S_AXI_WREADY,
  output logic [1:0]      S_AXI_BRESP,
  output logic            S_AXI_BVALID,
  input  wire logic       S_AXI_BREADY,
  input  wire logic [7:0] S_AXI_ARADDR,
  input  wire logic       S_AXI_ARVALID,
  output logic            S_AXI_ARREADY,
  output logic [31:0]     S_AXI_RDATA,
  output logic [1:0]      S_AXI_RRESP,
  output logic            S_AXI_RVALID,
  input  wire logic       S_AXI_RREADY
);
  host_state_t st;
  host_state_t next_st;
  logic [7:0]  waddr;
  logic [31:0] wdat;
  logic [3:0]  wstb;
  logic        clk_ok;
  logic        ref_ok;
  logic [4:0]  q;
  logic [2:0]  p;
  logic [7:0]  k;

  assign S_AXI_AWREADY = !st.aw_got && !st.bvalid;
  assign S_AXI_WREADY = !st.w_got && !st.bvalid;
  assign S_AXI_ARREADY = !st.rvalid;
  assign waddr = st.aw_got ? st.awaddr : S_AXI_AWADDR;
  assign wdat = st.w_got ? st.wdata : S_AXI_WDATA;
  assign wstb = st.w_got ? st.wstrb : S_AXI_WSTRB;
  assign q = wdat[4:0];
  assign p = wdat[14:12];
  assign k = wdat[23:16];

  always_comb begin
    clk_ok = 1'b1;
    if (wdat[`CLK_PLL]) begin
      if (q == 5'h05 || q == 5'h06 || q == 5'h07) begin
        clk_ok = (p == q[2:0]) && (k == 8'h10);
      end else if (q == 5'h0a || q == 5'h0e) begin
        clk_ok = (q == 5'h0a ? p == 3'h5 : p == 3'h7) && (k == 8'h08);
      end
    end else if (st.ctrl[`CTRL_DBL]) begin
      clk_ok = q == 5'h04 || q == 5'h08 || q == 5'h09 || q == 5'h0c || q == 5'h10;
    end
    ref_ok = !st.clkcfg[`CLK_PLL] ||
             (wdat[7:0] >= `REF_MIN_KHZ && wdat[7:0] <= `REF_MAX_KHZ);
  end

  always_comb begin
    next_st = st;
    next_st.cfg_we = 1'b0;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_st.w_got = 1'b1;
      next_st.wdata = S_AXI_WDATA;
      next_st.wstrb = S_AXI_WSTRB;
    end
    if (st.smp_valid && lk.smp_ready) begin
      next_st.smp_valid = 1'b0;
    end
    if (next_st.aw_got && next_st.w_got && !st.bvalid) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `RESP_OKAY;
      if (wstb != 4'hf) begin
        next_st.bresp = `RESP_SLVERR;
      end else if (waddr == `REG_CTRL) begin
        next_st.ctrl = wdat[3:0];
      end else if (waddr == `REG_RATE) begin
        next_st.rate = wdat[4:0];
      end else if (waddr == `REG_ATTEN) begin
        next_st.atten = wdat[15:0];
      end else if (waddr == `REG_COEF && !st.ctrl[`CTRL_FX] && !st.ctrl[`CTRL_3D]) begin
        next_st.cfg_we = 1'b1;
        next_st.cfg_addr = wdat[20:16];
        next_st.cfg_data = wdat[15:0];
      end else if (waddr == `REG_SAMPLE && !st.smp_valid) begin
        next_st.smp_valid = 1'b1;
        next_st.smp_left = wdat[31:16];
        next_st.smp_right = wdat[15:0];
      end else if (waddr == `REG_CLKCFG && clk_ok) begin
        next_st.clkcfg = wdat[23:0];
      end else if (waddr == `REG_REFRATE && ref_ok) begin
        next_st.refrate = wdat[7:0];
      end else begin
        next_st.bresp = `RESP_SLVERR;
      end
    end
    if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RESP_OKAY;
      if (S_AXI_ARADDR == `REG_CTRL) begin
        next_st.rdata = {28'h0000000, st.ctrl};
      end else if (S_AXI_ARADDR == `REG_RATE) begin
        next_st.rdata = {27'h0000000, st.rate};
      end else if (S_AXI_ARADDR == `REG_ATTEN) begin
        next_st.rdata = {16'h0000, st.atten};
      end else if (S_AXI_ARADDR == `REG_STATUS) begin
        next_st.rdata = {30'h00000000, lk.smp_ready, st.smp_valid};
      end else if (S_AXI_ARADDR == `REG_CLKCFG) begin
        next_st.rdata = {8'h00, st.clkcfg};
      end else if (S_AXI_ARADDR == `REG_REFRATE) begin
        next_st.rdata = {24'h000000, st.refrate};
      end else begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = `RESP_SLVERR;
      end
    end else if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= '0;
      st.rate <= 5'h01;
    end else begin
      st <= next_st;
    end
  end

  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;
  assign lk.smp_valid = st.smp_valid;
  assign lk.smp_left = st.smp_left;
  assign lk.smp_right = st.smp_right;
  assign lk.cfg_we = st.cfg_we;
  assign lk.cfg_addr = st.cfg_addr;
  assign lk.cfg_data = st.cfg_data;
  assign lk.fx_en = st.ctrl[`CTRL_FX];
  assign lk.deemph_en = st.ctrl[`CTRL_DEEMPH];
  assign lk.three_d_en = st.ctrl[`CTRL_3D];
  assign lk.double_rate = st.ctrl[`CTRL_DBL];
  assign lk.three_d_atten = st.atten;
  assign lk.dac_rate_divider = st.rate;
endmodule

// >>> sim/stereo_dac_playback_dsp_props.sv
// Checker of the playback link and of the converter outputs.
`timescale 1ns/1ps
module stereo_dac_playback_dsp_props
  import dac_dsp_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RSTN,
  input wire logic        smp_valid,
  input wire logic        smp_ready,
  input wire logic [15:0] smp_left,
  input wire logic [15:0] smp_right,
  input wire logic        cfg_we,
  input wire logic        fx_en,
  input wire logic        three_d_en,
  input wire logic [7:0]  DAC_LEFT,
  input wire logic [7:0]  DAC_RIGHT,
  input wire logic        DAC_STROBE
);
  logic [7:0] gap;
  logic       seen;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Cycles since the last modulator tick.
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      gap  <= 8'h00;
      seen <= 1'b0;
    end else if (DAC_STROBE) begin
      gap  <= 8'h00;
      seen <= 1'b1;
    end else if (gap != 8'hff) begin
      gap <= gap + 8'h01;
    end
  end
  property p_valid_hold;
    smp_valid && !smp_ready |=> smp_valid && $stable(smp_left) && $stable(smp_right);
  endproperty
  a_valid_hold: assert property (p_valid_hold)
    else $error("sample offer changed before it was taken");
  property p_valid_drop;
    smp_valid && smp_ready |=> !smp_valid;
  endproperty
  a_valid_drop: assert property (p_valid_drop)
    else $error("sample offered twice");
  property p_ready_stands;
    smp_ready && !smp_valid |=> smp_ready;
  endproperty
  a_ready_stands: assert property (p_ready_stands)
    else $error("open slot withdrawn without a sample");
  property p_ready_gap;
    (smp_valid && smp_ready) ##1 !smp_ready |=> !smp_ready [*8];
  endproperty
  a_ready_gap: assert property (p_ready_gap)
    else $error("slot reopened too soon after a sample");
  property p_cfg_pulse;
    cfg_we |=> !cfg_we;
  endproperty
  a_cfg_pulse: assert property (p_cfg_pulse)
    else $error("coefficient write longer than one cycle");
  property p_cfg_lock;
    cfg_we |-> !fx_en && !three_d_en;
  endproperty
  a_cfg_lock: assert property (p_cfg_lock)
    else $error("coefficient written while effects run");
  property p_strobe_rate;
    DAC_STROBE && seen |-> (gap == 8'd39) || (gap == 8'd40);
  endproperty
  a_strobe_rate: assert property (p_strobe_rate)
    else $error("modulator tick spacing wrong");
  property p_dac_on_strobe;
    !$stable(DAC_LEFT) || !$stable(DAC_RIGHT) |-> DAC_STROBE;
  endproperty
  a_dac_on_strobe: assert property (p_dac_on_strobe)
    else $error("converter output changed without a tick");
endmodule

// >>> sim/stereo_dac_playback_dsp_tb.sv
// Testbench of the playback controller and playback path joined by their link.
`timescale 1ns/1ps
`include "dac_dsp_regs.svh"
module stereo_dac_playback_dsp_tb
  import dac_dsp_pkg::*;
;
  localparam logic [15:0] XL = 16'h2000;
  localparam logic [15:0] XR = 16'he000;
  logic        clk;
  logic        rstn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  dac_left, dac_right;
  logic        dac_strobe;
  logic signed [31:0] sl, sr;
  int          seed, err_count, tests_run, i, n;
  logic [4:0]  ck_q [13] = '{4, 8, 9, 12, 16, 5, 10, 6, 5, 6, 7, 10, 14};
  logic        ck_pll [13] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1};
  logic [2:0]  ck_p [13] = '{0, 0, 0, 0, 0, 0, 0, 6, 5, 6, 7, 5, 7};
  logic [7:0]  ck_k [13] = '{0, 0, 0, 0, 0, 0, 0, 8, 16, 16, 16, 8, 8};
  logic [7:0]  ref_k [4] = '{38, 39, 53, 54};

  dac_link_if dac_link_if_inst (.CLK(clk), .RSTN(rstn));
  dac_playback_ctrl dac_playback_ctrl_inst (.lk(dac_link_if_inst), .CLK(clk), .RSTN(rstn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  dac_playback_path dac_playback_path_inst (.lk(dac_link_if_inst), .CLK(clk), .RSTN(rstn),
    .DAC_LEFT(dac_left), .DAC_RIGHT(dac_right), .DAC_STROBE(dac_strobe));
  stereo_dac_playback_dsp_props stereo_dac_playback_dsp_props_inst (.CLK(clk), .RSTN(rstn),
    .smp_valid(dac_link_if_inst.smp_valid), .smp_ready(dac_link_if_inst.smp_ready),
    .smp_left(dac_link_if_inst.smp_left), .smp_right(dac_link_if_inst.smp_right),
    .cfg_we(dac_link_if_inst.cfg_we), .fx_en(dac_link_if_inst.fx_en),
    .three_d_en(dac_link_if_inst.three_d_en), .DAC_LEFT(dac_left), .DAC_RIGHT(dac_right),
    .DAC_STROBE(dac_strobe));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Expected answer to a clock setting while double rate is on.
  function automatic logic [1:0] clk_resp(input logic [4:0] q, input logic pll,
                                          input logic [2:0] p, input logic [7:0] k);
    if (!pll) return (q inside {4, 8, 9, 12, 16}) ? `RESP_OKAY : `RESP_SLVERR;
    if ((q inside {5, 6, 7}) && (p == q[2:0]) && (k == 8'd16)) return `RESP_OKAY;
    if (((q == 5'd10 && p == 3'd5) || (q == 5'd14 && p == 3'd7)) && k == 8'd8) return `RESP_OKAY;
    return `RESP_SLVERR;
  endfunction
  // Average converter output for a constant input: six codes of step 2048.
  function automatic int dac_level(input int x);
    return 6 * x / 2048;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask
  task automatic chk_range(input string name, input int lo, input int hi,
                           input logic signed [31:0] got);
    tests_run++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      $display("CHECK FAILED %s expected %0d to %0d seen %0d", name, lo, hi, got);
      err_count++;
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s,
                           output logic [1:0] rs);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= dt;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (!w_done && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] er);
    logic [1:0] rs;
    axi_write(a, dt, 4'hf, rs);
    chk("write response", {30'h0, er}, {30'h0, rs});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("read data", ed, rdata);
    chk("read response", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic measure(output logic signed [31:0] ml, output logic signed [31:0] mr);
    ml = 0;
    mr = 0;
    repeat (32) begin
      do @(posedge clk); while (dac_strobe !== 1'b1);
      ml = ml + $signed(dac_left);
      mr = mr + $signed(dac_right);
    end
  endtask

  initial begin
    repeat (90000) @(posedge clk);
    err_count++;
    conclude();
  end

  initial begin
    seed = 79;
    err_count = 0;
    tests_run = 0;
    rstn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(`REG_CTRL, 32'h0, `RESP_OKAY);
    rd(`REG_RATE, 32'h1, `RESP_OKAY);
    rd(8'h20, 32'h0, `RESP_SLVERR);
    wr(`REG_STATUS, 32'h0, `RESP_SLVERR);
    axi_write(`REG_ATTEN, 32'h1234, 4'h3, r);
    chk("partial write response", {30'h0, `RESP_SLVERR}, {30'h0, r});
    rd(`REG_ATTEN, 32'h0, `RESP_OKAY);
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      wr(`REG_ATTEN, {16'h0, v[15:0]}, `RESP_OKAY);
      chk("link attenuation", {16'h0, v[15:0]}, {16'h0, dac_link_if_inst.three_d_atten});
      wr(`REG_RATE, {27'h0, v[20:16]}, `RESP_OKAY);
      chk("link divider", {27'h0, v[20:16]}, {27'h0, dac_link_if_inst.dac_rate_divider});
      wr(`REG_CTRL, {28'h0, v[27:24]}, `RESP_OKAY);
      chk("link modes", {28'h0, v[27:24]}, {28'h0, dac_link_if_inst.double_rate,
          dac_link_if_inst.three_d_en, dac_link_if_inst.deemph_en, dac_link_if_inst.fx_en});
      rd(`REG_CTRL, {28'h0, v[27:24]}, `RESP_OKAY);
    end
    wr(`REG_CTRL, 32'h1, `RESP_OKAY);
    wr(`REG_COEF, {16'h0, `DEF_DE_N0}, `RESP_SLVERR);
    wr(`REG_CTRL, 32'h4, `RESP_OKAY);
    wr(`REG_COEF, {16'h0, `DEF_DE_N0}, `RESP_SLVERR);
    wr(`REG_CTRL, 32'h0, `RESP_OKAY);
    wr(`REG_COEF, {11'h0, 5'h13, `DEF_BQ_NA}, `RESP_OKAY);
    wr(`REG_COEF, {16'h0, `DEF_DE_N0}, `RESP_OKAY);
    wr(`REG_RATE, 32'h1, `RESP_OKAY);
    wr(`REG_CTRL, 32'h8, `RESP_OKAY);
    for (i = 0; i < 13; i++) begin
      wr(`REG_CLKCFG, {8'h0, ck_k[i], 1'b0, ck_p[i], 3'h0, ck_pll[i], 3'h0, ck_q[i]},
         clk_resp(ck_q[i], ck_pll[i], ck_p[i], ck_k[i]));
    end
    for (i = 0; i < 4; i++) begin
      wr(`REG_REFRATE, {24'h0, ref_k[i]}, (ref_k[i] >= `REF_MIN_KHZ && ref_k[i] <= `REF_MAX_KHZ)
         ? `RESP_OKAY : `RESP_SLVERR);
    end
    wr(`REG_SAMPLE, {XL, XR}, `RESP_OKAY);
    rd(`REG_STATUS, 32'h1, `RESP_OKAY);
    wr(`REG_SAMPLE, {XL, XR}, `RESP_SLVERR);
    n = 1;
    while (n < 25) begin
      axi_write(`REG_SAMPLE, {XL, XR}, 4'hf, r);
      if (r === `RESP_OKAY) n++;
      if (r === `RESP_OKAY && n == 21) begin
        measure(sl, sr);
        chk_range("left before delay", 0, 0, sl);
        chk_range("right before delay", 0, 0, sr);
      end
    end
    measure(sl, sr);
    n = 32 * dac_level($signed(XL));
    chk_range("left level", n - 40, n + 40, sl);
    n = 32 * dac_level($signed(XR));
    chk_range("right level", n - 40, n + 40, sr);
    conclude();
  end
endmodule
